// [ipeb_pkg.sv]
// Purpose: shared constants of the interrupt priority and enable bank
// Assumes: 32-bit avalon data, registers in the low byte of each word
// Notes: register index times four gives the byte address
package ipeb_pkg;
    localparam logic [15:0] IDX_PRIO_A = 16'hFF10;
    localparam logic [15:0] IDX_PRIO_B = 16'hFF11;
    localparam logic [15:0] IDX_EN_PORT = 16'hFF14;
    localparam logic [15:0] IDX_EN_TLO = 16'hFF15;
    localparam logic [15:0] IDX_EN_SER = 16'hFF16;
    localparam logic [15:0] IDX_EN_TICK = 16'hFF17;
    localparam logic [15:0] IDX_EN_THI = 16'hFF18;
    localparam logic [15:0] IDX_STATUS = 16'hFF20;
    localparam logic [15:0] IDX_MASK = 16'hFF21;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] SER_RW_BITS = 8'h3F;
    localparam logic [7:0] TICK_RW_BITS = 8'h0F;
    localparam int NUM_SRC = 34;
    localparam int LVL_W = 68;
    localparam logic [5:0] VEC_NMI = 6'h02;
    localparam logic [5:0] VEC_FIRST = 6'h03;
    localparam logic [5:0] VEC_LAST = 6'h24;
    localparam logic [2:0] LVL_NMI = 3'h4;
    localparam logic [2:0] LVL_NONE = 3'h0;
    // status and mask bit positions, one per priority group
    localparam int GRP_PORT = 0;
    localparam int GRP_T32 = 1;
    localparam int GRP_T10 = 2;
    localparam int GRP_SER0 = 3;
    localparam int GRP_SER1 = 4;
    localparam int GRP_TICK = 5;
    localparam int GRP_T76 = 6;
    localparam int GRP_T54 = 7;
    typedef enum logic [0:0]
    {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } ipeb_bus_e;
endpackage : ipeb_pkg

// [ipeb_arb_if.sv]
// Purpose: carries pending sources and the winner between bank and arbiter
// Assumes: source bit 33 is first in vector order, bit 0 last
// Notes: levels are two bits per source, packed like the sources
`timescale 1ns/1ps
`default_nettype none
interface ipeb_arb_if;
    logic [33:0] pend;
    logic [67:0] lvl;
    logic [1:0] mask;
    logic nmi;
    logic win_valid;
    logic [2:0] win_level;
    logic [5:0] win_vector;
    modport ctl
    (
        output pend,
        output lvl,
        output mask,
        output nmi,
        input win_valid,
        input win_level,
        input win_vector
    );
    modport arb
    (
        input pend,
        input lvl,
        input mask,
        input nmi,
        output win_valid,
        output win_level,
        output win_vector
    );
endinterface : ipeb_arb_if
`default_nettype wire

// [ipeb_arbiter.sv]
// Purpose: picks the request passed to the cpu
// Assumes: inputs settle within one clock
// Notes: winner is registered, one cycle behind its inputs
`timescale 1ns/1ps
`default_nettype none
module ipeb_arbiter
(
    input wire logic clk_sys,
    input wire logic reset,
    ipeb_arb_if.arb a
);
    logic found;
    logic [2:0] best_lvl;
    logic [5:0] best_vec;

    always_comb
    begin
        found = 1'b0;
        best_lvl = ipeb_pkg::LVL_NONE;
        best_vec = 6'h00;
        // walk from last to first so earlier vectors win ties
        for (int k = 0; k < ipeb_pkg::NUM_SRC; k++)
        begin
            if (a.pend[k] && a.lvl[2*k +: 2] != 2'h0
                && {1'b0, a.lvl[2*k +: 2]} > {1'b0, a.mask}
                && {1'b0, a.lvl[2*k +: 2]} >= best_lvl)
            begin
                found = 1'b1;
                best_lvl = {1'b0, a.lvl[2*k +: 2]};
                best_vec = ipeb_pkg::VEC_FIRST + 6'(33 - k);
            end
        end
        if (a.nmi)
        begin
            found = 1'b1;
            best_lvl = ipeb_pkg::LVL_NMI;
            best_vec = ipeb_pkg::VEC_NMI;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            a.win_valid <= 1'b0;
            a.win_level <= ipeb_pkg::LVL_NONE;
            a.win_vector <= 6'h00;
        end
        else
        begin
            a.win_valid <= found;
            a.win_level <= best_lvl;
            a.win_vector <= best_vec;
        end
    end
endmodule : ipeb_arbiter
`default_nettype wire

// [ipeb_bank.sv]
// Purpose: interrupt priority and enable register bank with avalon slave
// Assumes: factor flags and cpu mask flags synchronous to clk_sys
// Notes: every access takes one wait cycle
`timescale 1ns/1ps
`default_nettype none
module ipeb_bank
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_flags,
    input wire logic [7:0] timer_low_flags,
    input wire logic [7:0] timer_high_flags,
    input wire logic [5:0] serial_flags,
    input wire logic [3:0] tick_flags,
    input wire logic watchdog_nmi,
    input wire logic cpu_mask_flag_hi,
    input wire logic cpu_mask_flag_lo,
    output logic cpu_irq_valid,
    output logic [2:0] cpu_irq_level,
    output logic [5:0] cpu_irq_vector,
    output logic irq
);
    ipeb_pkg::ipeb_bus_e bus_q;
    logic [15:0] idx;
    logic hit_ok;
    logic acc_wr;
    logic wr_lane;
    logic [7:0] wbyte;
    logic [7:0] prio_a_q;
    logic [7:0] prio_b_q;
    logic [7:0] en_port_q;
    logic [7:0] en_tlo_q;
    logic [7:0] en_thi_q;
    logic [7:0] en_ser_q;
    logic [7:0] en_tick_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] mask_q;
    logic [7:0] grp_req;
    logic [7:0] grp_req_q;
    logic [7:0] rd_clear;
    logic [31:0] rdata_q;

    ipeb_arb_if arb_bus ();

    function automatic logic [7:0] read_byte(input logic [15:0] i,
        input logic [7:0] pa, input logic [7:0] pb, input logic [7:0] ep,
        input logic [7:0] tl, input logic [7:0] th, input logic [7:0] sr,
        input logic [7:0] tk, input logic [7:0] st, input logic [7:0] mk);
        logic [7:0] r;
        r = 8'h00;
        case (i)
            ipeb_pkg::IDX_PRIO_A: r = pa;
            ipeb_pkg::IDX_PRIO_B: r = pb;
            ipeb_pkg::IDX_EN_PORT: r = ep;
            ipeb_pkg::IDX_EN_TLO: r = tl;
            ipeb_pkg::IDX_EN_THI: r = th;
            ipeb_pkg::IDX_EN_SER: r = sr & ipeb_pkg::SER_RW_BITS;
            ipeb_pkg::IDX_EN_TICK: r = tk & ipeb_pkg::TICK_RW_BITS;
            ipeb_pkg::IDX_STATUS: r = st;
            ipeb_pkg::IDX_MASK: r = mk;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_byte

    function automatic logic group_active(input logic [7:0] bits,
        input logic [1:0] lvl);
        return (|bits) && (lvl != 2'h0);
    endfunction : group_active

    // bus decode: byte address, aligned words only
    assign idx = avs_address[17:2];
    assign hit_ok = (avs_address[1:0] == 2'h0);
    assign avs_waitrequest = (avs_read || avs_write)
        && (bus_q != ipeb_pkg::BUS_DONE);
    assign acc_wr = avs_write && (bus_q == ipeb_pkg::BUS_DONE);
    assign wr_lane = acc_wr && hit_ok && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            bus_q <= ipeb_pkg::BUS_IDLE;
        else
        begin
            unique case (bus_q)
                ipeb_pkg::BUS_IDLE:
                    if (avs_read || avs_write)
                        bus_q <= ipeb_pkg::BUS_DONE;
                ipeb_pkg::BUS_DONE:
                    bus_q <= ipeb_pkg::BUS_IDLE;
            endcase
        end
    end

    // read data captured in the wait cycle, stands through the answer
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdata_q <= 32'h0000_0000;
        else if (avs_read && bus_q == ipeb_pkg::BUS_IDLE)
            rdata_q <= {24'h00_0000, hit_ok ? read_byte(idx, prio_a_q,
                prio_b_q, en_port_q, en_tlo_q, en_thi_q, en_ser_q,
                en_tick_q, status_q, mask_q) : 8'h00};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prio_a_q <= ipeb_pkg::RESET_BYTE;
            prio_b_q <= ipeb_pkg::RESET_BYTE;
        end
        else if (wr_lane && idx == ipeb_pkg::IDX_PRIO_A)
            prio_a_q <= wbyte;
        else if (wr_lane && idx == ipeb_pkg::IDX_PRIO_B)
            prio_b_q <= wbyte;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            en_port_q <= ipeb_pkg::RESET_BYTE;
            en_tlo_q <= ipeb_pkg::RESET_BYTE;
            en_thi_q <= ipeb_pkg::RESET_BYTE;
            en_ser_q <= ipeb_pkg::RESET_BYTE;
            en_tick_q <= ipeb_pkg::RESET_BYTE;
        end
        else if (wr_lane)
        begin
            if (idx == ipeb_pkg::IDX_EN_PORT)
                en_port_q <= wbyte;
            if (idx == ipeb_pkg::IDX_EN_TLO)
                en_tlo_q <= wbyte;
            if (idx == ipeb_pkg::IDX_EN_THI)
                en_thi_q <= wbyte;
            if (idx == ipeb_pkg::IDX_EN_SER)
                en_ser_q <= wbyte & ipeb_pkg::SER_RW_BITS;
            if (idx == ipeb_pkg::IDX_EN_TICK)
                en_tick_q <= wbyte & ipeb_pkg::TICK_RW_BITS;
        end
    end

    // sources in vector order; timer bit layout already matches it
    assign arb_bus.pend = {port_flags & en_port_q,
        timer_low_flags & en_tlo_q,
        serial_flags[2:0] & en_ser_q[2:0],
        serial_flags[5:3] & en_ser_q[5:3],
        tick_flags & en_tick_q[3:0],
        timer_high_flags & en_thi_q};
    assign arb_bus.lvl = {{8{prio_a_q[1:0]}}, {4{prio_a_q[3:2]}},
        {4{prio_a_q[5:4]}}, {3{prio_a_q[7:6]}}, {3{prio_b_q[1:0]}},
        {4{prio_b_q[3:2]}}, {4{prio_b_q[5:4]}},
        {4{prio_b_q[7:6]}}};
    assign arb_bus.mask = {cpu_mask_flag_hi, cpu_mask_flag_lo};
    assign arb_bus.nmi = watchdog_nmi;

    ipeb_arbiter u_arb
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .a(arb_bus)
    );

    assign cpu_irq_valid = arb_bus.win_valid;
    assign cpu_irq_level = arb_bus.win_level;
    assign cpu_irq_vector = arb_bus.win_vector;

    // group events: a group starts requesting
    assign grp_req[ipeb_pkg::GRP_PORT] =
        group_active(arb_bus.pend[33:26], prio_a_q[1:0]);
    assign grp_req[ipeb_pkg::GRP_T32] =
        group_active({4'h0, arb_bus.pend[25:22]}, prio_a_q[3:2]);
    assign grp_req[ipeb_pkg::GRP_T10] =
        group_active({4'h0, arb_bus.pend[21:18]}, prio_a_q[5:4]);
    assign grp_req[ipeb_pkg::GRP_SER0] =
        group_active({5'h00, arb_bus.pend[17:15]}, prio_a_q[7:6]);
    assign grp_req[ipeb_pkg::GRP_SER1] =
        group_active({5'h00, arb_bus.pend[14:12]}, prio_b_q[1:0]);
    assign grp_req[ipeb_pkg::GRP_TICK] =
        group_active({4'h0, arb_bus.pend[11:8]}, prio_b_q[3:2]);
    assign grp_req[ipeb_pkg::GRP_T76] =
        group_active({4'h0, arb_bus.pend[7:4]}, prio_b_q[5:4]);
    assign grp_req[ipeb_pkg::GRP_T54] =
        group_active({4'h0, arb_bus.pend[3:0]}, prio_b_q[7:6]);

    // clear only bits that the read returned, so a late event survives
    assign rd_clear = (avs_read && bus_q == ipeb_pkg::BUS_DONE
        && hit_ok && idx == ipeb_pkg::IDX_STATUS) ? rdata_q[7:0] : 8'h00;
    assign status_d = (status_q & ~rd_clear) | (grp_req & ~grp_req_q);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            status_q <= 8'h00;
            grp_req_q <= 8'h00;
        end
        else
        begin
            status_q <= status_d;
            grp_req_q <= grp_req;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mask_q <= 8'h00;
        else if (wr_lane && idx == ipeb_pkg::IDX_MASK)
            mask_q <= wbyte;
    end

    assign irq = |(status_q & mask_q);

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    prio_reset_a: assert property ($fell(reset) |->
        prio_a_q == 8'h00 && prio_b_q == 8'h00 && en_port_q == 8'h00)
        else $error("priority or enable not cleared by reset");
    prio_write_a: assert property (wr_lane
        && idx == ipeb_pkg::IDX_PRIO_B |=> prio_b_q == $past(wbyte))
        else $error("priority write lost");
    timer_field_a: assert property (arb_bus.lvl[43:42] == prio_a_q[5:4]
        && arb_bus.lvl[51:50] == prio_a_q[3:2]
        && arb_bus.lvl[1:0] == prio_b_q[7:6]
        && arb_bus.lvl[15:14] == prio_b_q[5:4])
        else $error("timer level field misplaced");
    port_field_a: assert property (arb_bus.lvl[67:66] == prio_a_q[1:0]
        && arb_bus.lvl[53:52] == prio_a_q[1:0])
        else $error("port level field misplaced");
    tick_field_a: assert property (arb_bus.lvl[17:16] == prio_b_q[3:2])
        else $error("tick level field misplaced");
    serial_field_a: assert property (arb_bus.lvl[35:34] == prio_a_q[7:6]
        && arb_bus.lvl[25:24] == prio_b_q[1:0])
        else $error("serial level field misplaced");
    enable_gate_a: assert property (en_port_q == 8'h00
        && en_tlo_q == 8'h00 && en_thi_q == 8'h00 && en_ser_q == 8'h00
        && en_tick_q == 8'h00 && !watchdog_nmi |=> !cpu_irq_valid)
        else $error("request without any enable");
    reserved_zero_a: assert property (en_ser_q[7:6] == 2'h0
        && en_tick_q[7:4] == 4'h0)
        else $error("reserved enable bit set");
    tick_write_a: assert property (wr_lane
        && idx == ipeb_pkg::IDX_EN_TICK
        |=> en_tick_q == ($past(wbyte) & 8'h0F))
        else $error("tick enable write wrong");
    nmi_accept_a: assert property (watchdog_nmi |=> cpu_irq_valid
        && cpu_irq_level == 3'h4 && cpu_irq_vector == 6'h02)
        else $error("watchdog request not taken");
    mask_level_a: assert property (cpu_irq_valid
        && cpu_irq_level != 3'h4 |-> cpu_irq_level
        > {1'b0, $past(cpu_mask_flag_hi), $past(cpu_mask_flag_lo)})
        else $error("request at or below cpu mask");
    fixed_order_a: assert property (!watchdog_nmi
        && arb_bus.pend[33] && prio_a_q[1:0] == 2'h3
        && !(cpu_mask_flag_hi && cpu_mask_flag_lo)
        |=> cpu_irq_vector == 6'h03)
        else $error("first vector did not win");
    level_nonzero_a: assert property (cpu_irq_valid |->
        cpu_irq_level != 3'h0 && cpu_irq_vector <= 6'h24)
        else $error("request at level zero");
    status_set_a: assert property (grp_req[0] && !grp_req_q[0]
        |=> status_q[0])
        else $error("group event lost");

    nmi_c: cover property (watchdog_nmi ##1 cpu_irq_valid);
    tie_c: cover property (arb_bus.pend[33] && arb_bus.pend[26]
        && prio_a_q[1:0] != 2'h0 ##1 cpu_irq_valid);
    status_clear_c: cover property (rd_clear != 8'h00 ##1 !irq);
    masked_c: cover property (|arb_bus.pend && cpu_mask_flag_hi
        && cpu_mask_flag_lo ##1 !cpu_irq_valid);
endmodule : ipeb_bank
`default_nettype wire

// [ipeb_cpu_model.sv]
// Purpose: core cpu stand-in on the far side of the request outputs
// Assumes: bench picks the mask level the cpu would hold
// Notes: flags are not raised on acceptance, so levels stay put
`timescale 1ns/1ps
`default_nettype none
module ipeb_cpu_model
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] mask_level,
    input wire logic irq_valid,
    input wire logic [5:0] irq_vector,
    output logic cpu_mask_flag_hi,
    output logic cpu_mask_flag_lo,
    output logic [5:0] taken_vector
);
    // flags change only between instructions, so registered
    always_ff @(posedge clk_sys)
    begin
        cpu_mask_flag_hi <= mask_level[1];
        cpu_mask_flag_lo <= mask_level[0];
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            taken_vector <= 6'h00;
        else if (irq_valid)
            taken_vector <= irq_vector;
    end
endmodule : ipeb_cpu_model
`default_nettype wire

// [ipeb_bank_tb.sv]
// Purpose: self-checking bench for the priority and enable bank
// Assumes: one wait cycle per access, winner one edge behind inputs
// Notes: vectors follow the fixed hardware order, P27 first
`timescale 1ns/1ps
`default_nettype none
module ipeb_bank_tb;
    localparam int LIMIT = 20000;
    logic clk_sys, reset, avs_read, avs_write, watchdog_nmi, irq;
    logic avs_waitrequest, cpu_mask_flag_hi, cpu_mask_flag_lo;
    logic cpu_irq_valid;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, tick_flags;
    logic [2:0] cpu_irq_level;
    logic [5:0] cpu_irq_vector, taken_vector, serial_flags;
    logic [7:0] port_flags, timer_low_flags, timer_high_flags;
    logic [1:0] mask_level;
    int compares, miscompares, cycles;
    logic [15:0] regs [9] = '{16'hFF10, 16'hFF11, 16'hFF14, 16'hFF15,
        16'hFF16, 16'hFF17, 16'hFF18, 16'hFF21, 16'hFF20};
    logic [7:0] wv [8] = '{8'h5A, 8'hA5, 8'hC3, 8'h3C, 8'hFF, 8'hFF,
        8'h96, 8'h81};
    logic [7:0] rv [8] = '{8'h5A, 8'hA5, 8'hC3, 8'h3C, 8'h3F, 8'h0F,
        8'h96, 8'h81};
    // one group per entry: flag source, bit, field, expected vector
    logic [15:0] enr [5] = '{16'hFF14, 16'hFF15, 16'hFF18, 16'hFF16,
        16'hFF17};
    int gsel [8] = '{0, 1, 1, 3, 3, 4, 2, 2};
    logic [7:0] gval [8] = '{8'h01, 8'h40, 8'h01, 8'h01, 8'h20, 8'h01,
        8'h80, 8'h01};
    logic [7:0] gpa [8] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00};
    logic [7:0] gpb [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04,
        8'h10, 8'h40};
    logic [5:0] gvec [8] = '{6'h0A, 6'h0C, 6'h12, 6'h15, 6'h16, 6'h1C,
        6'h1D, 6'h24};

    ipeb_bank i_dut
    (
        .clk_sys, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .port_flags, .timer_low_flags, .timer_high_flags, .serial_flags,
        .tick_flags, .watchdog_nmi, .cpu_mask_flag_hi, .cpu_mask_flag_lo,
        .cpu_irq_valid, .cpu_irq_level, .cpu_irq_vector, .irq
    );
    ipeb_cpu_model i_cpu
    (
        .clk_sys, .reset, .mask_level, .irq_valid(cpu_irq_valid),
        .irq_vector(cpu_irq_vector), .cpu_mask_flag_hi, .cpu_mask_flag_lo,
        .taken_vector
    );

    task complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    // starts and ends on a rising edge; answer taken at the rising edge
    // that sees wait low, so a longer wait still lands correctly
    task bus(input logic w_en, input logic [17:0] adr,
        input logic [7:0] wd, input logic [3:0] be);
        logic w;
        int n;
        n = 0;
        avs_address <= adr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= w_en;
        avs_read <= !w_en;
        do
        begin
            @(posedge clk_sys);
            n++;
            w = avs_waitrequest;
            rd = avs_readdata;
        end
        while (w !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // slave promises exactly one wait cycle per access
        check(32'(n), 32'h00000002);
        // one idle edge so the next request is a fresh assignment
        @(posedge clk_sys);
    endtask : bus

    task wr(input logic [15:0] idx, input logic [7:0] v);
        bus(1'b1, {idx, 2'b00}, v, 4'hF);
    endtask : wr

    task rdchk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, {idx, 2'b00}, 8'h00, 4'hF);
        check(rd, 32'(exp));
    endtask : rdchk

    task set_flags(input logic [7:0] p, l, h, s, t);
        port_flags <= p;
        timer_low_flags <= l;
        timer_high_flags <= h;
        serial_flags <= s[5:0];
        tick_flags <= t[3:0];
        repeat (3) @(posedge clk_sys);
    endtask : set_flags

    task req_chk(input logic v, input logic [2:0] l, input logic [5:0] x);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        if (v)
            check(32'({cpu_irq_valid, cpu_irq_level, cpu_irq_vector}),
                32'({v, l, x}));
        else
            check(32'(cpu_irq_valid), 32'h00000000);
        @(posedge clk_sys);
    endtask : req_chk

    task irq_chk(input logic exp);
        @(negedge clk_sys);
        check(32'(irq), 32'(exp));
        @(posedge clk_sys);
    endtask : irq_chk

    function automatic logic [7:0] pick(input int s, input int k,
        input logic [7:0] v);
        return (s == k) ? v : 8'h00;
    endfunction : pick

    task t_reset();
        reset <= 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int k = 0; k < 9; k++)
            rdchk(regs[k], 8'h00);
        check(32'(cpu_irq_valid), 32'h00000000);
    endtask : t_reset

    task t_regs();
        for (int k = 0; k < 8; k++)
            wr(regs[k], wv[k]);
        for (int k = 0; k < 8; k++)
            rdchk(regs[k], rv[k]);
        bus(1'b1, {16'hFF10, 2'b00}, 8'h00, 4'hE);
        bus(1'b1, {16'hFF11, 2'b01}, 8'h00, 4'hF);
        rdchk(16'hFF10, 8'h5A);
        rdchk(16'hFF11, 8'hA5);
        wr(16'hFF12, 8'hFF);
        rdchk(16'hFF12, 8'h00);
        bus(1'b0, {16'hFF10, 2'b10}, 8'h00, 4'hF);
        check(rd, 32'h00000000);
    endtask : t_regs

    task t_levels();
        wr(16'hFF14, 8'h80);
        wr(16'hFF11, 8'h00);
        set_flags(8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
        for (int l = 0; l < 4; l++)
            for (int m = 0; m < 4; m++)
            begin
                wr(16'hFF10, 8'(l));
                mask_level <= 2'(m);
                req_chk(l > m, 3'(l), 6'h03);
            end
        // highest cpu mask still lets the watchdog through
        mask_level <= 2'h3;
        watchdog_nmi <= 1'b1;
        req_chk(1'b1, 3'h4, 6'h02);
        check(32'(taken_vector), 32'h00000002);
        watchdog_nmi <= 1'b0;
        mask_level <= 2'h0;
    endtask : t_levels

    task t_groups();
        int s;
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            s = gsel[i];
            v = gval[i];
            set_flags(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
            for (int k = 0; k < 5; k++)
                wr(enr[k], pick(s, k, v));
            wr(16'hFF10, gpa[i]);
            wr(16'hFF11, gpb[i]);
            bus(1'b0, {16'hFF20, 2'b00}, 8'h00, 4'hF);
            set_flags(pick(s, 0, v), pick(s, 1, v), pick(s, 2, v),
                pick(s, 3, v), pick(s, 4, v));
            req_chk(1'b1, 3'h1, gvec[i]);
            rdchk(16'hFF20, 8'(1 << i));
            // own field cleared, every other field at level 3
            wr(16'hFF10, ~(gpa[i] * 8'h03));
            wr(16'hFF11, ~(gpb[i] * 8'h03));
            req_chk(1'b0, 3'h0, 6'h00);
        end
    endtask : t_groups

    task t_order();
        for (int k = 0; k < 5; k++)
            wr(enr[k], 8'hFF);
        wr(16'hFF10, 8'hAA);
        wr(16'hFF11, 8'hAA);
        set_flags(8'h01, 8'h00, 8'h01, 8'h00, 8'h08);
        req_chk(1'b1, 3'h2, 6'h0A);
        wr(16'hFF14, 8'h00);
        req_chk(1'b1, 3'h2, 6'h19);
        wr(16'hFF11, 8'hEA);
        req_chk(1'b1, 3'h3, 6'h24);
    endtask : t_order

    task t_irq();
        set_flags(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(16'hFF10, 8'h01);
        wr(16'hFF11, 8'h04);
        wr(16'hFF14, 8'h01);
        wr(16'hFF17, 8'h01);
        wr(16'hFF21, 8'h01);
        bus(1'b0, {16'hFF20, 2'b00}, 8'h00, 4'hF);
        irq_chk(1'b0);
        set_flags(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
        irq_chk(1'b1);
        rdchk(16'hFF20, 8'h01);
        irq_chk(1'b0);
        set_flags(8'h01, 8'h00, 8'h00, 8'h00, 8'h01);
        irq_chk(1'b0);
        rdchk(16'hFF20, 8'h20);
    endtask : t_irq

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // hang guard, far above the roughly 730 cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares++;
            complete_run();
        end
    end

    initial
    begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 18'h00000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        port_flags = 8'h00;
        timer_low_flags = 8'h00;
        timer_high_flags = 8'h00;
        serial_flags = 6'h00;
        tick_flags = 4'h0;
        watchdog_nmi = 1'b0;
        mask_level = 2'h0;
        t_reset();
        t_regs();
        t_levels();
        t_groups();
        t_order();
        t_irq();
        t_reset();
        complete_run();
    end
endmodule : ipeb_bank_tb
`default_nettype wire
